// ==== hw/mdc_pkg.sv ====
// Package of constants and types for the multidrop direction control block
package mdc_pkg;
  // Register byte addresses
  localparam logic [31:0] MDC_ADDR_CTRL = 32'h4000804c;
  localparam logic [31:0] MDC_ADDR_MATCH = 32'h40008050;
  localparam logic [31:0] MDC_ADDR_DELAY = 32'h40008054;
  localparam logic [31:0] MDC_ADDR_STAT = 32'h40008060;
  localparam logic [31:0] MDC_ADDR_MASK = 32'h40008064;
  // Control field positions
  localparam int MDC_CTRL_PLAIN = 0;
  localparam int MDC_CTRL_RXOFF = 1;
  localparam int MDC_CTRL_AUTO = 2;
  localparam int MDC_CTRL_SEL = 3;
  localparam int MDC_CTRL_TURN = 4;
  localparam int MDC_CTRL_POL = 5;
  localparam int MDC_CTRL_W = 6;
  // Status bit positions
  localparam int MDC_ST_ADDR = 0;
  localparam int MDC_ST_DATA = 1;
  localparam int MDC_ST_DROP = 2;
  localparam int MDC_ST_W = 3;
  // Reset values
  localparam logic [5:0] MDC_CTRL_RST = 6'h00;
  localparam logic [7:0] MDC_MATCH_RST = 8'h00;
  localparam logic [7:0] MDC_DELAY_RST = 8'h00;
  // AXI responses
  localparam logic [1:0] MDC_RESP_OK = 2'h0;
  localparam logic [1:0] MDC_RESP_ERR = 2'h2;
  // Turnaround states
  typedef enum logic [1:0] {
    MDC_IDLE = 2'b00,
    MDC_SEND = 2'b01,
    MDC_HOLD = 2'b10
  } mdc_dir_t;
  // Control register fields
  typedef struct packed {
    logic turnaround_polarity;
    logic auto_turnaround_on;
    logic pin_select;
    logic auto_station_detect_on;
    logic receiver_off;
    logic plain_multidrop_on;
  } mdc_ctrl_t;
  // Received character from the port
  typedef struct packed {
    logic valid;
    logic parity_err;
    logic [7:0] data;
  } mdc_rx_t;
endpackage

// ==== hw/mdc_turnaround.sv ====
// Direction signal generator with baud-timed release delay
`timescale 1ns/1ns
`default_nettype none
module mdc_turnaround
  import mdc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Configuration
  input wire logic i_enable,
  input wire logic i_polarity,
  input wire logic [7:0] i_delay,
  // Transmitter state
  input wire logic i_tx_busy,
  input wire logic i_baud_tick,
  // Direction level, already polarised
  output logic o_dir
);
  mdc_dir_t state_q;
  logic [7:0] count_q; // Release countdown
  logic active; // Direction asserted

  // Sequence: idle, sending, holding for delay
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= MDC_IDLE;
      count_q <= 8'h00;
    end else if (!i_enable) begin
      state_q <= MDC_IDLE;
      count_q <= 8'h00;
    end else begin
      unique case (state_q)
        MDC_IDLE: begin
          if (i_tx_busy) begin
            state_q <= MDC_SEND;
          end
        end
        MDC_SEND: begin
          if (!i_tx_busy) begin
            count_q <= i_delay;
            state_q <= MDC_HOLD;
          end
        end
        MDC_HOLD: begin
          if (i_tx_busy) begin
            state_q <= MDC_SEND; // New data restarts send phase
          end else if (count_q == 8'h00) begin
            state_q <= MDC_IDLE;
          end else if (i_baud_tick) begin
            count_q <= count_q - 8'h01;
          end
        end
        default: begin
          state_q <= MDC_IDLE;
        end
      endcase
    end
  end

  // Zero delay releases one clock after the last stop bit is gone
  assign active = (state_q == MDC_SEND) || i_tx_busy ||
                  ((state_q == MDC_HOLD) && (count_q != 8'h00));
  // Polarity zero: low while sending; one: high
  assign o_dir = i_polarity ? active : !active;
endmodule
`default_nettype wire

// ==== hw/mdc_top.sv ====
// Multidrop direction control block with AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
module mdc_top
  import mdc_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  // AXI4-Lite write address
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_AWADDR,
  // AXI4-Lite write data
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  // AXI4-Lite write response
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // AXI4-Lite read address
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [31:0] I_ARADDR,
  // AXI4-Lite read data
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // Receive side of the port
  // Received characters arrive as one-cycle pulses
  input wire logic I_RX_VALID,
  input wire logic [7:0] I_RX_DATA,
  input wire logic I_RX_PARITY_ERR,
  output logic O_RX_VALID,
  output logic [7:0] O_RX_DATA,
  output logic O_RX_IS_ADDR,
  // Transmit side of the port
  // Busy stays high until the last stop bit has left
  input wire logic I_TX_BUSY,
  input wire logic I_BAUD_TICK,
  // Modem control pins, active low by default
  // Inputs are the port's own levels, used when a pin is not steered
  input wire logic I_RTS_N,
  input wire logic I_DTR_N,
  output logic O_RTS_N,
  output logic O_DTR_N,
  // Interrupt
  // Level output, high while an unmasked event is pending
  output logic O_IRQ
);
  // Software-visible registers
  mdc_ctrl_t ctrl_q; // Control register
  logic [7:0] match_q; // Station match value
  logic [7:0] delay_q; // Turnaround delay
  logic [MDC_ST_W-1:0] stat_q; // Sticky events
  logic [MDC_ST_W-1:0] mask_q; // Interrupt mask
  // Bus channel state
  logic [31:0] awaddr_q; // Latched write address
  logic [31:0] wdata_q; // Latched write data
  logic [3:0] wstrb_q; // Latched strobes
  logic aw_have_q; // Write address held
  logic w_have_q; // Write data held
  logic bvalid_q; // Write response pending
  logic [1:0] bresp_q;
  logic rvalid_q; // Read data pending
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  // Receive path state
  logic listen_q; // Station addressed
  mdc_rx_t rx_in; // Bundled received character
  logic rx_take; // Character accepted by receiver
  logic is_addr; // Character is an address byte
  // Write strobe, status events and direction
  logic do_write; // Both halves of a write present
  logic [MDC_ST_W-1:0] ev; // Event pulses this cycle
  logic [MDC_ST_W-1:0] st_clr; // Write-one-to-clear bits
  logic dir; // Direction from generator

  // Word address decode, true when address is mapped
  // Unmapped offsets answer with an error and read as zero
  // Only whole-word addresses match; offsets inside a word do not
  function automatic logic mapped(input logic [31:0] a);
    return (a == MDC_ADDR_CTRL) || (a == MDC_ADDR_MATCH) || (a == MDC_ADDR_DELAY) ||
           (a == MDC_ADDR_STAT) || (a == MDC_ADDR_MASK);
  endfunction

  // Apply byte-lane 0 strobe to an 8-bit field
  // Every field sits in the low byte, so upper lanes carry nothing
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    return s[0] ? d[7:0] : old;
  endfunction

  // Received character lines bundled for the filter logic
  assign rx_in = '{valid: I_RX_VALID, parity_err: I_RX_PARITY_ERR, data: I_RX_DATA};
  // Readies drop while a half is held, refusing a second one
  assign O_AWREADY = !aw_have_q;
  assign O_WREADY = !w_have_q;
  // Answers come straight from their registers
  assign O_BVALID = bvalid_q;
  assign O_BRESP = bresp_q;
  // A read is refused while its answer still stands
  assign O_ARREADY = !rvalid_q;
  assign O_RVALID = rvalid_q;
  assign O_RDATA = rdata_q;
  assign O_RRESP = rresp_q;
  // Perform the write once both halves are held and no answer waits
  assign do_write = aw_have_q && w_have_q && !bvalid_q;

  // Write address and data capture, either order
  // Each half is held until the write is performed
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 32'h00000000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      // Address half
      if (I_AWVALID && !aw_have_q) begin
        aw_have_q <= 1'b1;
        awaddr_q <= I_AWADDR;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      // Data half with its byte strobes
      if (I_WVALID && !w_have_q) begin
        w_have_q <= 1'b1;
        wdata_q <= I_WDATA;
        wstrb_q <= I_WSTRB;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response, error on unmapped address
  // The answer stands until the master raises its ready
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      bvalid_q <= 1'b0;
      bresp_q <= MDC_RESP_OK;
    end else if (do_write) begin
      // Error response when the address maps to no register
      bvalid_q <= 1'b1;
      bresp_q <= mapped(awaddr_q) ? MDC_RESP_OK : MDC_RESP_ERR;
    end else if (I_BREADY) begin
      // Released at the edge that takes it
      bvalid_q <= 1'b0;
    end
  end

  // Configuration registers, lane 0 only
  // Writes without the lane 0 strobe leave every field as it is
  // Bits above each field are dropped and read back as zero
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      // All fields start at zero
      ctrl_q <= MDC_CTRL_RST;
      match_q <= MDC_MATCH_RST;
      delay_q <= MDC_DELAY_RST;
      mask_q <= '0;
    end else if (do_write && wstrb_q[0]) begin
      unique case (awaddr_q)
        MDC_ADDR_CTRL: ctrl_q <= wdata_q[MDC_CTRL_W-1:0];
        MDC_ADDR_MATCH: match_q <= lane0(match_q, wdata_q, wstrb_q);
        MDC_ADDR_DELAY: delay_q <= lane0(delay_q, wdata_q, wstrb_q);
        MDC_ADDR_MASK: mask_q <= wdata_q[MDC_ST_W-1:0];
        // Status is cleared elsewhere; unmapped offsets do nothing
        default: begin
        end
      endcase
    end
  end

  // Read channel, one-cycle answer
  // Data are sampled from the registers at the taking edge
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= MDC_RESP_OK;
    end else if (I_ARVALID && !rvalid_q) begin
      rvalid_q <= 1'b1;
      // Unmapped reads answer with an error
      rresp_q <= mapped(I_ARADDR) ? MDC_RESP_OK : MDC_RESP_ERR;
      unique case (I_ARADDR)
        MDC_ADDR_CTRL: rdata_q <= {26'h0, ctrl_q};
        MDC_ADDR_MATCH: rdata_q <= {24'h0, match_q};
        MDC_ADDR_DELAY: rdata_q <= {24'h0, delay_q};
        MDC_ADDR_STAT: rdata_q <= {29'h0, stat_q};
        MDC_ADDR_MASK: rdata_q <= {29'h0, mask_q};
        // Unmapped offsets read as zero
        default: rdata_q <= 32'h00000000;
      endcase
    end else if (I_RREADY) begin
      // Answer released at the edge that takes it
      rvalid_q <= 1'b0;
    end
  end

  // Receive gating and address classification
  // A disabled receiver drops characters before the station, status and valid logic see them
  assign rx_take = rx_in.valid && !ctrl_q.receiver_off;
  // Parity error marks an address byte in either multidrop mode
  assign is_addr = rx_in.parity_err &&
                   (ctrl_q.plain_multidrop_on || ctrl_q.auto_station_detect_on);

  // Station addressing state for auto detect
  // Listening starts on a matching address byte and ends on any other
  // Turning auto detect off forgets the last address
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      listen_q <= 1'b0;
    end else if (!ctrl_q.auto_station_detect_on) begin
      listen_q <= 1'b0;
    end else if (rx_take && is_addr) begin
      // Compare the whole byte with the station match value
      listen_q <= (rx_in.data == match_q);
    end
  end

  // Event pulses for the status register
  // Only accepted characters raise events
  always_comb begin
    ev = '0;
    if (rx_take) begin
      // Address, data and dropped-data events
      ev[MDC_ST_ADDR] = is_addr;
      ev[MDC_ST_DATA] = !is_addr;
      ev[MDC_ST_DROP] = ctrl_q.auto_station_detect_on && !is_addr && !listen_q;
    end
  end

  // Delivered character, address bytes withheld in auto mode
  // A character is delivered one cycle after it arrives
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RX_VALID <= 1'b0;
      O_RX_DATA <= 8'h00;
      O_RX_IS_ADDR <= 1'b0;
    end else begin
      O_RX_VALID <= rx_take && (!ctrl_q.auto_station_detect_on ||
                    (!is_addr && listen_q));
      // Data and address flag are registered every cycle
      O_RX_DATA <= rx_in.data;
      O_RX_IS_ADDR <= is_addr;
    end
  end

  // Sticky status, set wins over write-one clear
  // An event in the same cycle as its clear keeps the bit set
  assign st_clr = (do_write && wstrb_q[0] && awaddr_q == MDC_ADDR_STAT) ?
                  wdata_q[MDC_ST_W-1:0] : '0;
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      stat_q <= '0;
    end else begin
      // Clear first, then let new events win
      stat_q <= (stat_q & ~st_clr) | ev;
    end
  end

  // Level interrupt from unmasked status
  // Stays high until software clears or masks every enabled bit
  assign O_IRQ = |(stat_q & mask_q);

  // Direction generator
  // Produces the polarised direction level from the transmitter state
  mdc_turnaround u_turn (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_enable(ctrl_q.auto_turnaround_on),
    .i_polarity(ctrl_q.turnaround_polarity),
    .i_delay(delay_q),
    .i_tx_busy(I_TX_BUSY),
    .i_baud_tick(I_BAUD_TICK),
    .o_dir(dir)
  );

  // Pin steering; unselected pin keeps the port's own modem level
  // Both pins idle high in reset, the inactive level of a low-active line
  // The selected pin takes the direction one cycle after the generator
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RTS_N <= 1'b1;
      O_DTR_N <= 1'b1;
    end else begin
      // Default: pass the port's own modem levels through
      O_RTS_N <= I_RTS_N;
      O_DTR_N <= I_DTR_N;
      // Direction overrides the chosen pin only while enabled
      if (ctrl_q.auto_turnaround_on) begin
        // Select bit: zero steers to the request pin, one to the ready pin
        if (ctrl_q.pin_select) begin
          O_DTR_N <= dir;
        end else begin
          O_RTS_N <= dir;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/mdc_checker.sv ====
// Port-level checker of bus handshakes and receive timing
`timescale 1ns/1ns
`default_nettype none
module mdc_checker (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  // Bus handshakes
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  // Receive path
  input wire logic I_RX_VALID,
  input wire logic I_RX_PARITY_ERR,
  input wire logic O_RX_VALID,
  input wire logic O_RX_IS_ADDR,
  input wire logic [7:0] I_RX_DATA,
  input wire logic [7:0] O_RX_DATA
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_ARST_N);
  a_rx_follows: assert property (O_RX_VALID |-> $past(I_RX_VALID))
    else $error("char accepted without input");
  a_addr_parity: assert property (O_RX_VALID && O_RX_IS_ADDR |-> $past(I_RX_PARITY_ERR))
    else $error("address byte without parity error");
  a_rx_data: assert property (O_RX_VALID |-> O_RX_DATA == $past(I_RX_DATA))
    else $error("accepted char altered");
  a_read_lat: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  a_write_lat: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
    |-> ##[1:2] O_BVALID) else $error("write answer late");
  a_b_done: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("write answer repeated");
  a_r_done: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
    else $error("read answer repeated");
  a_ar_refused: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read taken while answer pending");
endmodule
bind mdc_top mdc_checker chk_u (.I_CLK, .I_ARST_N, .I_AWVALID, .O_AWREADY, .I_WVALID,
  .O_WREADY, .O_BVALID, .I_BREADY, .I_ARVALID, .O_ARREADY, .O_RVALID, .I_RREADY,
  .I_RX_VALID, .I_RX_PARITY_ERR, .O_RX_VALID, .O_RX_IS_ADDR, .I_RX_DATA, .O_RX_DATA);
`default_nettype wire

// ==== tb/mdc_node.sv ====
// Model of a far bus node that delivers received characters
`timescale 1ns/1ns
`default_nettype none
module mdc_node (
  // Clock
  input wire logic i_clk,
  // Received character lines
  output logic o_valid,
  output logic o_perr,
  output logic [7:0] o_data
);
  initial begin
    o_valid = 1'b0;
    o_perr = 1'b0;
    o_data = 8'h00;
  end
  // One character per call; released lines show the inverse value
  task automatic send(input logic [7:0] d, input logic pe);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_data <= d;
    o_perr <= pe;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_data <= ~d;
    o_perr <= ~pe;
    #1;
  endtask
endmodule
`default_nettype wire

// ==== tb/test_rs485_multidrop_direction_ctrl.sv ====
// Testbench of registers, receive filtering, interrupt and direction control
`timescale 1ns/1ns
`default_nettype none
module test_rs485_multidrop_direction_ctrl
  import mdc_pkg::*;
;
  logic clk = 0, rst_n = 0, aw = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic busy = 0, tick = 0, rts_n = 1, dtr_n = 0, rxv, rxp;
  logic [31:0] awa = 0, wd = 0, ara = 0;
  logic [7:0] rxd;
  wire logic awr, wrdy, bv, arr, rv, orv, oadr, orts, odtr, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdat;
  wire logic [7:0] ord;
  int errors = 0, total_checks = 0;
  localparam logic [1:0] OK = MDC_RESP_OK;
  always #25 clk = ~clk;
  mdc_node nd (.i_clk(clk), .o_valid(rxv), .o_perr(rxp), .o_data(rxd));
  mdc_top dut_u (.I_CLK(clk), .I_ARST_N(rst_n), .I_AWVALID(aw), .O_AWREADY(awr),
    .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wrdy), .I_WDATA(wd), .I_WSTRB(4'hf),
    .O_BVALID(bv), .I_BREADY(br), .O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(arr),
    .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rr), .O_RDATA(rdat), .O_RRESP(rresp),
    .I_RX_VALID(rxv), .I_RX_DATA(rxd), .I_RX_PARITY_ERR(rxp), .O_RX_VALID(orv),
    .O_RX_DATA(ord), .O_RX_IS_ADDR(oadr), .I_TX_BUSY(busy), .I_BAUD_TICK(tick),
    .I_RTS_N(rts_n), .I_DTR_N(dtr_n), .O_RTS_N(orts), .O_DTR_N(odtr), .O_IRQ(irq));
  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // A wait that ran out ends the run
  task automatic limit(input int n);
    if (n >= 40) begin
      errors++;
      $display("wrong value at %0t: no bus answer", $time);
      test_done();
    end
  endtask
  // Bus write, address and data offered together
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    aw <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    br <= 1'b1;
    for (n = 0; n < 40 && (aw || wv); n++) begin
      @(posedge clk);
      if (awr) aw <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end
    for (n = 0; n < 40 && !bv; n++) @(posedge clk);
    limit(n);
    br <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask
  // Bus read with expected data and response
  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    for (n = 0; n < 40 && !(arv && arr); n++) @(posedge clk);
    arv <= 1'b0;
    for (n = 0; n < 40 && !rv; n++) @(posedge clk);
    limit(n);
    rr <= 1'b0;
    chk(rdat, ed);
    chk(32'(rresp), 32'(er));
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(MDC_ADDR_CTRL, 32'h0, OK);
    rd(MDC_ADDR_MATCH, 32'h0, OK);
    rd(MDC_ADDR_DELAY, 32'h0, OK);
    rd(32'h40008058, 32'h0, MDC_RESP_ERR);
    wr(32'h40008058, 32'h1, MDC_RESP_ERR);
    wr(MDC_ADDR_MATCH, 32'h15a, OK);
    rd(MDC_ADDR_MATCH, 32'h5a, OK);
    wr(MDC_ADDR_DELAY, 32'h103, OK);
    rd(MDC_ADDR_DELAY, 32'h3, OK);
    // Plain mode marks parity-error bytes and filters nothing
    wr(MDC_ADDR_CTRL, 32'h1, OK);
    nd.send(8'h33, 1'b1);
    chk({22'h0, orv, oadr, ord}, 32'h333);
    nd.send(8'h44, 1'b0);
    chk({22'h0, orv, oadr, ord}, 32'h244);
    wr(MDC_ADDR_CTRL, 32'h3, OK);
    nd.send(8'h44, 1'b0);
    chk(32'(orv), 32'h0);
    // Auto mode passes data only behind a matching address
    wr(MDC_ADDR_STAT, 32'h7, OK);
    wr(MDC_ADDR_CTRL, 32'h4, OK);
    nd.send(8'h5a, 1'b1);
    chk(32'(orv), 32'h0);
    nd.send(8'h11, 1'b0);
    chk({22'h0, orv, oadr, ord}, 32'h211);
    nd.send(8'h33, 1'b1);
    nd.send(8'h22, 1'b0);
    chk(32'(orv), 32'h0);
    // Sticky status, mask and write-one clear
    rd(MDC_ADDR_STAT, 32'h7, OK);
    chk(32'(irq), 32'h0);
    wr(MDC_ADDR_MASK, 32'h4, OK);
    chk(32'(irq), 32'h1);
    wr(MDC_ADDR_STAT, 32'h4, OK);
    chk(32'(irq), 32'h0);
    rd(MDC_ADDR_STAT, 32'h3, OK);
    // Direction on the request pin low-active, then on the ready pin high-active
    for (int k = 0; k < 2; k++) begin
      wr(MDC_ADDR_CTRL, k ? 32'h38 : 32'h10, OK);
      busy <= 1'b1;
      repeat (4) @(posedge clk);
      chk({30'h0, orts, odtr}, k ? 32'h3 : 32'h0);
      busy <= 1'b0;
      ticks(2);
      repeat (2) @(posedge clk);
      chk({30'h0, orts, odtr}, k ? 32'h3 : 32'h0);
      ticks(1);
      repeat (3) @(posedge clk);
      chk({30'h0, orts, odtr}, 32'h2);
    end
    wr(MDC_ADDR_CTRL, 32'h0, OK);
    busy <= 1'b1;
    repeat (4) @(posedge clk);
    chk({30'h0, orts, odtr}, 32'h2);
    busy <= 1'b0;
    // Mid-run reset returns the pins and the fields to their reset levels
    wr(MDC_ADDR_MATCH, 32'h66, OK);
    wr(MDC_ADDR_CTRL, 32'h10, OK);
    busy <= 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({30'h0, orts, odtr}, 32'h3);
    rst_n <= 1'b1;
    busy <= 1'b0;
    rd(MDC_ADDR_MATCH, 32'h0, OK);
    rd(MDC_ADDR_CTRL, 32'h0, OK);
    test_done();
  end
endmodule
`default_nettype wire
